/* File: shared/rpm_pkg.sv */
// constants and carrier types for the receive pattern mask and clock out block
// assumes one clock domain and a 32-bit APB register port
package rpm_pkg;

    localparam int REG_W     = 16;
    localparam int PAT_REGS  = 32;
    localparam int MASK_REGS = 4;
    localparam int PAT_BYTES = 64;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_PAT_FIRST   = 10'h13C;
    localparam logic [9:0] IDX_PAT_LAST    = 10'h15B;
    localparam logic [9:0] IDX_MASK_LO     = 10'h15C;
    localparam logic [9:0] IDX_MASK_SECOND = 10'h15D;
    localparam logic [9:0] IDX_MASK_THIRD  = 10'h15E;
    localparam logic [9:0] IDX_MASK_HI     = 10'h15F;
    localparam logic [9:0] IDX_START       = 10'h161;
    localparam logic [9:0] IDX_RATE_CFG    = 10'h16F;
    localparam logic [9:0] IDX_IO_CFG      = 10'h170;

    // field positions
    localparam int START_LSB    = 0;
    localparam int START_W      = 6;
    localparam int RATE_BIT_POS = 7;
    localparam int CLK_SEL_LSB  = 8;
    localparam int CLK_SEL_W    = 5;
    localparam int CLK_DIS_POS  = 6;
    localparam int IMP_LSB      = 0;
    localparam int IMP_W        = 5;

    // values after reset
    localparam logic [15:0] MASK_RST      = 16'h0000;
    localparam logic [15:0] PAT_RST       = 16'h0000;
    localparam logic [5:0]  START_RST     = 6'h00;
    localparam logic        RATE_BIT_RST  = 1'b0;
    localparam logic [6:0]  RATE_FIXED_LO = 7'h15;
    localparam logic [4:0]  CLK_SEL_RST   = 5'h0C;
    localparam logic        CLK_DIS_RST   = 1'b0;

    // clock output select codes
    localparam logic [4:0] CLK_RX_DIRECT_LAST = 5'h03;
    localparam logic [4:0] CLK_RX_DIV_FIRST   = 5'h04;
    localparam logic [4:0] CLK_RX_DIV_LAST    = 5'h07;
    localparam logic [4:0] CLK_TX_FIRST       = 5'h08;
    localparam logic [4:0] CLK_TX_LAST        = 5'h0B;
    localparam logic [4:0] CLK_REF            = 5'h0C;

    // divide-by-five counter of receive clock edges
    localparam logic [2:0] DIV_LAST = 3'h4;
    localparam logic [2:0] DIV_HIGH = 3'h3;

    typedef struct packed {
        logic       ref_clk;
        logic [3:0] tx;
        logic [3:0] rx;
    } rpm_chan_clk_type;

    typedef struct packed {
        logic       sof;
        logic       eof;
        logic       valid;
        logic [7:0] data;
    } rpm_rx_byte_type;

endpackage

/* File: hw/rpm_clk_sel.sv */
// clock output selector with divide-by-five for receive clocks
// assumes channel clock levels arrive synchronous to mclk
`timescale 1ns/1ps
module rpm_clk_sel
    import rpm_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             srst,
    input  rpm_chan_clk_type      chanClk,
    input  wire logic [4:0]       clkSel,
    input  wire logic             clkDisable,
    output logic                  clkOut
);

    logic [2:0] divCnt;
    logic       rxPrev;

    wire [1:0] chanIdx    = clkSel[1:0];
    wire       isRxDirect = clkSel <= CLK_RX_DIRECT_LAST;
    wire       isRxDiv    = (clkSel >= CLK_RX_DIV_FIRST) && (clkSel <= CLK_RX_DIV_LAST);
    wire       isTx       = (clkSel >= CLK_TX_FIRST) && (clkSel <= CLK_TX_LAST);
    wire       isRef      = clkSel == CLK_REF;
    wire       rxLevel    = chanClk.rx[chanIdx];
    wire       rxRise     = rxLevel && !rxPrev;
    wire       divLevel   = divCnt < DIV_HIGH;
    // reserved codes give a quiet low output
    wire       next_clkOut = clkDisable ? 1'b0 :                     // RQ10
                             isRef      ? chanClk.ref_clk :          // RQ6
                             isTx       ? chanClk.tx[chanIdx] :      // RQ7
                             isRxDiv    ? divLevel :                 // RQ8
                             isRxDirect ? rxLevel : 1'b0;            // RQ9

    always_ff @(posedge mclk) begin
        if (srst) begin
            rxPrev <= 1'b0;
            divCnt <= 3'h0;
            clkOut <= 1'b0;
        end else begin
            rxPrev <= rxLevel;
            if (rxRise) begin
                divCnt <= (divCnt == DIV_LAST) ? 3'h0 : divCnt + 3'h1; // RQ8
            end
            clkOut <= next_clkOut;
        end
    end

    property p_ref_route;
        @(posedge mclk) disable iff (srst)
        (isRef && !clkDisable) |=> (clkOut == $past(chanClk.ref_clk));
    endproperty
    a_ref_route: assert property (p_ref_route) else $error("ref clock not routed"); // RQ6

    property p_tx_route;
        @(posedge mclk) disable iff (srst)
        (isTx && !clkDisable) |=> (clkOut == $past(chanClk.tx[chanIdx]));
    endproperty
    a_tx_route: assert property (p_tx_route) else $error("tx clock not routed"); // RQ7

    property p_div_wrap;
        @(posedge mclk) disable iff (srst)
        (rxRise && divCnt == DIV_LAST) |=> (divCnt == 3'h0) ##0 (divLevel == 1'b1);
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap at five"); // RQ8

    property p_reserved_low;
        @(posedge mclk) disable iff (srst)
        (clkSel > CLK_REF) |=> !clkOut;
    endproperty
    a_reserved_low: assert property (p_reserved_low) else $error("reserved code drives clock"); // RQ9

    property p_disable_low;
        @(posedge mclk) disable iff (srst)
        clkDisable [*2] |-> !clkOut;
    endproperty
    a_disable_low: assert property (p_disable_low) else $error("disabled clock output toggles"); // RQ10

endmodule // rpm_clk_sel

/* File: hw/rpm_top.sv */
// register slice for receive pattern masks, compare start and clock out config
// assumes APB3 master on mclk, synchronous receive byte stream and channel clocks
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps

// Behaviour
// RQ1 - Four 16-bit mask registers give 64 mask bits, bytes 0-15 in the lowest upward.
// RQ2 - A mask bit of one leaves its pattern byte out of the comparison, zero keeps it.
// RQ3 - The 6-bit start offset picks the byte after the delimiter where comparison begins.
// RQ4 - Bits 15:6 of the start offset register ignore writes and read zero.
// RQ5 - Rate adaptation is automatic and software leaves the rate adaptation bit alone.
// RQ6 - Clock select 01100, the reset value, routes the reference clock out.
// RQ7 - Clock select 01000 to 01011 route the transmit clock of channels A to D out.
// RQ8 - Clock select 00100 to 00111 route the receive clock of A to D divided by five.
// RQ9 - Clock select 01101 to 11111 are reserved and give no defined clock.
// RQ10 - The clock disable bit stops the clock output when one and is zero after reset.
// RQ11 - A 5-bit impedance field picks one of 32 steps, 11111 lowest and 00000 highest.
// RQ12 - The impedance field resets to a factory trim value rather than a constant.
// RQ13 - The pattern is held two bytes per 16-bit register, each byte maskable.
// RQ14 - A match is declared only when every unmasked byte from the start offset agrees.
module rpm_top
    import rpm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  rpm_rx_byte_type        rxByte,
    input  rpm_chan_clk_type       chanClk,
    input  wire logic [IMP_W-1:0]  trimImpedance,
    output logic                   matchPulse,
    output logic                   clkOut,
    output logic [IMP_W-1:0]       ioImpedance,
    output logic                   slowRateAdapt
);

    generate
        if (ADDR_W < 12) begin : g_bad_addr
            $error("rpm_top: ADDR_W too small for the register map");
        end
    endgenerate

    logic [15:0]          patReg [PAT_REGS];
    logic [15:0]          maskReg [MASK_REGS];
    logic [START_W-1:0]   startOffset;
    logic [CLK_SEL_W-1:0] clkSel;
    logic                 clkDisable;
    logic [6:0]           byteIdx;
    logic                 active;
    logic                 failed;
    logic [9:0]           rdIdx;

    // APB decode
    wire [9:0] regIdx     = paddr[11:2];
    wire       setupPhase = psel && !penable;
    wire       accessDone = psel && penable && pready;
    wire       patHit     = (regIdx >= IDX_PAT_FIRST) && (regIdx <= IDX_PAT_LAST);
    wire       maskHit    = (regIdx >= IDX_MASK_LO) && (regIdx <= IDX_MASK_HI);
    wire       startHit   = regIdx == IDX_START;
    wire       rateHit    = regIdx == IDX_RATE_CFG;
    wire       ioHit      = regIdx == IDX_IO_CFG;
    wire       mapped     = patHit || maskHit || startHit || rateHit || ioHit;
    wire       wrEn       = accessDone && pwrite && mapped;
    wire [9:0] patOff     = regIdx - IDX_PAT_FIRST;
    wire [9:0] maskOff    = regIdx - IDX_MASK_LO;
    wire [4:0] patSel     = patOff[4:0];
    wire [1:0] maskSel    = maskOff[1:0];

    wire [15:0] startRead = {10'h000, startOffset};                       // RQ4
    wire [15:0] rateRead  = {8'h00, slowRateAdapt, RATE_FIXED_LO};
    wire [15:0] ioRead    = {3'h0, clkSel, 1'b0, clkDisable, 1'b0, ioImpedance};
    wire [15:0] readVal   = patHit   ? patReg[patSel] :
                            maskHit  ? maskReg[maskSel] :
                            startHit ? startRead :
                            rateHit  ? rateRead :
                            ioHit    ? ioRead : 16'h0000;

    always_ff @(posedge mclk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            rdIdx   <= 10'h000;
        end else begin
            pready  <= setupPhase;
            pslverr <= setupPhase && !mapped;
            if (setupPhase) begin
                rdIdx <= regIdx;
            end
            if (setupPhase && !pwrite) begin
                prdata <= {16'h0000, readVal};
            end
        end
    end

    // pattern and mask storage, flattened for byte selection
    logic [PAT_BYTES*8-1:0] patFlat;
    logic [PAT_BYTES-1:0]   maskFlat;

    genvar gi;
    generate
        for (gi = 0; gi < PAT_REGS; gi++) begin : g_pat
            always_ff @(posedge mclk) begin
                if (srst) begin
                    patReg[gi] <= PAT_RST;
                end else if (wrEn && patHit && patSel == 5'(gi)) begin
                    patReg[gi] <= pwdata[15:0];                            // RQ13
                end
            end
            // low byte is the even pattern byte
            assign patFlat[16*gi +: 16] = patReg[gi];                      // RQ13
        end
        for (gi = 0; gi < MASK_REGS; gi++) begin : g_mask
            always_ff @(posedge mclk) begin
                if (srst) begin
                    maskReg[gi] <= MASK_RST;
                end else if (wrEn && maskHit && maskSel == 2'(gi)) begin
                    maskReg[gi] <= pwdata[15:0];                           // RQ1
                end
            end
            assign maskFlat[16*gi +: 16] = maskReg[gi];                    // RQ1
        end
    endgenerate

    // control registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            startOffset   <= START_RST;
            slowRateAdapt <= RATE_BIT_RST;
            clkSel        <= CLK_SEL_RST;                                  // RQ6
            clkDisable    <= CLK_DIS_RST;                                  // RQ10
            ioImpedance   <= trimImpedance;                                // RQ12
        end else if (wrEn) begin
            if (startHit) begin
                startOffset <= pwdata[START_LSB +: START_W];               // RQ4
            end
            if (rateHit) begin
                // stored only; the rate adapts on its own whatever this says
                slowRateAdapt <= pwdata[RATE_BIT_POS];                     // RQ5
            end
            if (ioHit) begin
                clkSel      <= pwdata[CLK_SEL_LSB +: CLK_SEL_W];
                clkDisable  <= pwdata[CLK_DIS_POS];
                ioImpedance <= pwdata[IMP_LSB +: IMP_W];                   // RQ11
            end
        end
    end

    // pattern compare on the receive byte stream
    wire [6:0] relIdx   = byteIdx - {1'b0, startOffset};
    wire       inWindow = active && (byteIdx >= {1'b0, startOffset}) && !relIdx[6]; // RQ3
    wire [8:0] bitBase  = {relIdx[5:0], 3'b000};
    wire [7:0] patByte  = patFlat[bitBase +: 8];
    wire       maskBit  = maskFlat[relIdx[5:0]];
    wire       byteMiss = !maskBit && (rxByte.data != patByte);            // RQ2
    wire       cmpByte  = inWindow && rxByte.valid;
    wire       lastByte = cmpByte && (relIdx[5:0] == 6'h3F);

    always_ff @(posedge mclk) begin
        if (srst) begin
            active     <= 1'b0;
            failed     <= 1'b0;
            byteIdx    <= 7'h00;
            matchPulse <= 1'b0;
        end else begin
            matchPulse <= lastByte && !failed && !byteMiss && !rxByte.sof;  // RQ14
            if (rxByte.sof) begin
                active  <= 1'b1;
                failed  <= 1'b0;
                byteIdx <= 7'h00;                                          // RQ3
            end else if (rxByte.eof) begin
                // a frame cut short never matches
                active <= 1'b0;
            end else if (rxByte.valid && active) begin
                byteIdx <= byteIdx + 7'h01;
                failed  <= failed || (cmpByte && byteMiss);                // RQ14
                if (lastByte) begin
                    active <= 1'b0;
                end
            end
        end
    end

    rpm_clk_sel u_clk_sel (
        .mclk       (mclk),
        .srst       (srst),
        .chanClk    (chanClk),
        .clkSel     (clkSel),
        .clkDisable (clkDisable),
        .clkOut     (clkOut)
    );

    property p_mask_readback;
        @(posedge mclk) disable iff (srst)
        (accessDone && !pwrite && maskHit && rdIdx == regIdx)
            |-> (prdata[15:0] == maskReg[maskSel]) && (prdata[31:16] == 16'h0000);
    endproperty
    a_mask_readback: assert property (p_mask_readback) else $error("mask read-back wrong"); // RQ1

    property p_masked_no_fail;
        @(posedge mclk) disable iff (srst)
        (cmpByte && maskBit && !rxByte.sof && !rxByte.eof && !lastByte)
            |=> (failed == $past(failed));
    endproperty
    a_masked_no_fail: assert property (p_masked_no_fail) else $error("masked byte compared"); // RQ2

    property p_start_point;
        @(posedge mclk) disable iff (srst)
        (active && byteIdx == {1'b0, startOffset}) |-> inWindow && (relIdx == 7'h00);
    endproperty
    a_start_point: assert property (p_start_point) else $error("compare start misplaced"); // RQ3

    property p_start_upper_zero;
        @(posedge mclk) disable iff (srst)
        (accessDone && !pwrite && rdIdx == IDX_START) |-> (prdata[31:6] == 26'h0);
    endproperty
    a_start_upper_zero: assert property (p_start_upper_zero) else $error("start upper bits set"); // RQ4

    property p_rate_fixed;
        @(posedge mclk) disable iff (srst)
        (accessDone && !pwrite && rdIdx == IDX_RATE_CFG)
            |-> (prdata[6:0] == RATE_FIXED_LO) && (prdata[7] == slowRateAdapt);
    endproperty
    a_rate_fixed: assert property (p_rate_fixed) else $error("rate register read wrong"); // RQ5

    property p_imp_write;
        @(posedge mclk) disable iff (srst)
        (wrEn && ioHit) |=> (ioImpedance == $past(pwdata[4:0])) && (clkSel == $past(pwdata[12:8]));
    endproperty
    a_imp_write: assert property (p_imp_write) else $error("io config write lost"); // RQ11

    property p_trim_reset;
        @(posedge mclk)
        srst |=> (ioImpedance == $past(trimImpedance)) && (clkSel == CLK_SEL_RST) && !clkDisable;
    endproperty
    a_trim_reset: assert property (p_trim_reset) else $error("io config reset wrong"); // RQ12

    property p_pattern_write;
        @(posedge mclk) disable iff (srst)
        (wrEn && patHit) |=> (patReg[$past(patSel)] == $past(pwdata[15:0]));
    endproperty
    a_pattern_write: assert property (p_pattern_write) else $error("pattern write lost"); // RQ13

    property p_match_cause;
        @(posedge mclk) disable iff (srst)
        matchPulse |-> $past(lastByte) && !$past(failed) && !$past(byteMiss);
    endproperty
    a_match_cause: assert property (p_match_cause) else $error("match without full agreement"); // RQ14

    property p_ready_one;
        @(posedge mclk) disable iff (srst)
        setupPhase |=> pready ##1 !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready not one cycle");

    property p_err_unmapped;
        @(posedge mclk) disable iff (srst)
        (setupPhase && !mapped) |=> pready && pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");

    property p_unmapped_quiet;
        @(posedge mclk) disable iff (srst)
        (accessDone && pwrite && !mapped)
            |=> $stable(startOffset) && $stable(clkSel) && $stable(maskFlat);
    endproperty
    a_unmapped_quiet: assert property (p_unmapped_quiet) else $error("unmapped write landed");

    property p_unmapped_read_zero;
        @(posedge mclk) disable iff (srst)
        (accessDone && !pwrite && !mapped && rdIdx == regIdx) |-> (prdata == 32'h0000_0000);
    endproperty
    a_unmapped_read_zero: assert property (p_unmapped_read_zero) else $error("unmapped read");

    property p_mask_write;
        @(posedge mclk) disable iff (srst)
        (wrEn && maskHit) |=> (maskReg[$past(maskSel)] == $past(pwdata[15:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // RQ1

    property p_start_write;
        @(posedge mclk) disable iff (srst)
        (wrEn && startHit) |=> (startOffset == $past(pwdata[START_W-1:0]));
    endproperty
    a_start_write: assert property (p_start_write) else $error("start write lost"); // RQ3

    property p_rate_store;
        @(posedge mclk) disable iff (srst)
        (wrEn && rateHit) |=> (slowRateAdapt == $past(pwdata[RATE_BIT_POS]));
    endproperty
    a_rate_store: assert property (p_rate_store) else $error("rate bit write lost"); // RQ5

    property p_dis_write;
        @(posedge mclk) disable iff (srst)
        (wrEn && ioHit) |=> (clkDisable == $past(pwdata[CLK_DIS_POS]));
    endproperty
    a_dis_write: assert property (p_dis_write) else $error("clock disable write lost"); // RQ10

    property p_miss_fails;
        @(posedge mclk) disable iff (srst)
        (cmpByte && byteMiss && !rxByte.sof && !rxByte.eof) |=> failed;
    endproperty
    a_miss_fails: assert property (p_miss_fails) else $error("miss not recorded"); // RQ14

    property p_match_single;
        @(posedge mclk) disable iff (srst)
        matchPulse |=> !matchPulse;
    endproperty
    a_match_single: assert property (p_match_single) else $error("match pulse too long"); // RQ14

endmodule // rpm_top

/* File: bench/rpm_testbench.sv */
// self-checking bench for rpm_top: apb registers, pattern match and clock output
// assumes rpm_pkg is compiled first; mclk at 200 MHz, srst synchronous active high
`timescale 1ns/1ps
module testbench;
    import rpm_pkg::*;

    typedef struct {
        int   due;
        logic val;
    } rpm_note_type;

    logic             mclk          = 1'b0;
    logic             srst          = 1'b1;
    logic             psel          = 1'b0;
    logic             penable       = 1'b0;
    logic             pwrite        = 1'b0;
    logic [11:0]      paddr         = 12'h000;
    logic [31:0]      pwdata        = 32'h0000_0000;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    rpm_rx_byte_type  rxByte        = '0;
    rpm_chan_clk_type chanClk       = '0;
    logic [4:0]       trimImpedance = 5'h00;
    logic             matchPulse;
    logic             clkOut;
    logic [4:0]       ioImpedance;
    logic             slowRateAdapt;

    int               seed          = 32'h3A5094E5;
    int               mismatches    = 0;
    int               tests_run     = 0;
    int               cyc           = 0;
    logic [4:0]       impNow;
    logic [7:0]       pat [64];
    logic [33:0]      apbQ [$];
    logic [33:0]      apbNote;
    rpm_note_type     matchQ [$];
    rpm_note_type     clkQ [$];

    always #2.5 mclk = ~mclk;

    rpm_top rpm_top_i (
        .mclk          (mclk),
        .srst          (srst),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .rxByte        (rxByte),
        .chanClk       (chanClk),
        .trimImpedance (trimImpedance),
        .matchPulse    (matchPulse),
        .clkOut        (clkOut),
        .ioImpedance   (ioImpedance),
        .slowRateAdapt (slowRateAdapt)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // monitor: takes the oldest note whenever a result shows up
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (psel && penable && pready) begin
            apbNote = apbQ.pop_front();
            check({31'h0, pslverr}, {31'h0, apbNote[32]});
            if (apbNote[33]) check(prdata, apbNote[31:0]);
        end
        if (matchQ.size() > 0 && matchQ[0].due == cyc) begin
            check({31'h0, matchPulse}, {31'h0, matchQ[0].val});
            void'(matchQ.pop_front());
        end else if (matchPulse !== 1'b0) begin
            check({31'h0, matchPulse}, 32'h0);
        end
        if (clkQ.size() > 0 && clkQ[0].due == cyc) begin
            check({31'h0, clkOut}, {31'h0, clkQ[0].val});
            void'(clkQ.pop_front());
        end
        // the only way out of a hung handshake
        if (cyc > 20000) begin
            mismatches++;
            results();
        end
    end

    // one whole apb transfer; entered just after a rising edge
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] data,
                       input logic err, input logic [15:0] exp);
        apbQ.push_back({~wr, err, 16'h0000, exp});
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {16'($random(seed)), data};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    // sof, s lead bytes, then len pattern bytes with byte bad flipped
    task automatic frame(input int s, input int bad, input int len, input logic exp);
        int i;
        rpm_note_type nt;
        rxByte <= '{sof: 1'b1, eof: 1'b0, valid: 1'b0, data: 8'h00};
        for (i = 0; i < s + len; i++) begin
            @(posedge mclk);
            rxByte <= '{1'b0, 1'b0, 1'b1, (i < s) ? 8'($random(seed)) :
                        pat[i - s] ^ ((i - s == bad) ? 8'h01 : 8'h00)};
        end
        nt.due = cyc + 2;
        nt.val = exp;
        matchQ.push_back(nt);
        @(posedge mclk);
        rxByte <= '{1'b0, 1'b1, 1'b0, 8'h00};
        @(posedge mclk);
        rxByte <= '0;
        @(posedge mclk);
    endtask

    // src 0..3 rx, 4..7 tx, 8 reference, negative for none
    task automatic clk_run(input logic [4:0] code, input logic dis, input int src);
        int i;
        rpm_chan_clk_type cc;
        rpm_note_type nt;
        apb(1'b1, IDX_IO_CFG, {3'h0, code, 1'b0, dis, 1'b0, impNow}, 1'b0, 16'h0000);
        for (i = 0; i < 24; i++) begin
            cc = 9'($random(seed));
            chanClk <= cc;
            nt.due = cyc + 2;
            nt.val = (dis || src < 0) ? 1'b0 : (src < 4) ? cc.rx[src] :
                     (src < 8) ? cc.tx[src - 4] : cc.ref_clk;
            clkQ.push_back(nt);
            @(posedge mclk);
        end
    endtask

    // other channels run at a different rate so a wrong pick shows in the count
    task automatic div_run(input int ch);
        int i;
        int rises;
        logic prev;
        rpm_chan_clk_type cc;
        apb(1'b1, IDX_IO_CFG, {3'h0, CLK_RX_DIV_FIRST + 5'(ch), 3'h0, impNow}, 1'b0, 16'h0000);
        rises = 0;
        prev = 1'b0;
        for (i = 0; i < 260; i++) begin
            cc = '0;
            cc.rx = {4{i % 6 >= 3}};
            cc.rx[ch] = i[1];
            chanClk <= cc;
            if (i >= 60 && clkOut === 1'b1 && prev === 1'b0) rises++;
            prev = clkOut;
            @(posedge mclk);
        end
        check(rises, 10);
    endtask

    initial begin
        logic [4:0]  impTab [3];
        logic [4:0]  codes [11];
        int          srcs [11];
        logic [15:0] v;
        impTab = '{5'h00, 5'h1F, 5'h0A};
        codes = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h1F};
        srcs = '{0, 1, 2, 3, 4, 5, 6, 7, 8, -1, -1};
        trimImpedance = 5'($random(seed));
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        impNow = trimImpedance;
        trimImpedance <= ~trimImpedance;
        @(posedge mclk);
        apb(1'b0, IDX_IO_CFG, 16'h0000, 1'b0, {3'h0, CLK_SEL_RST, 3'h0, impNow});
        check({27'h0, ioImpedance}, {27'h0, impNow});
        apb(1'b0, IDX_RATE_CFG, 16'h0000, 1'b0, {8'h00, RATE_BIT_RST, RATE_FIXED_LO});
        for (int m = 0; m < 4; m++) apb(1'b0, IDX_MASK_LO + 10'(m), 16'h0000, 1'b0, 16'h0000);
        apb(1'b0, IDX_START, 16'h0000, 1'b0, 16'h0000);
        // unmapped places refuse and read zero
        apb(1'b1, 10'h160, 16'hFFFF, 1'b1, 16'h0000);
        apb(1'b0, 10'h160, 16'h0000, 1'b1, 16'h0000);
        apb(1'b0, 10'h000, 16'h0000, 1'b1, 16'h0000);
        apb(1'b1, IDX_START, 16'hFFFF, 1'b0, 16'h0000);
        apb(1'b0, IDX_START, 16'h0000, 1'b0, 16'h003F);
        // rate bit itself is left at its default
        apb(1'b1, IDX_RATE_CFG, 16'hFF7F, 1'b0, 16'h0000);
        apb(1'b0, IDX_RATE_CFG, 16'h0000, 1'b0, 16'h0015);
        check({31'h0, slowRateAdapt}, 32'h0);
        foreach (impTab[k]) begin
            impNow = impTab[k];
            apb(1'b1, IDX_IO_CFG, {3'h7, CLK_REF, 3'h5, impNow}, 1'b0, 16'h0000);
            apb(1'b0, IDX_IO_CFG, 16'h0000, 1'b0, {3'h0, CLK_REF, 3'h0, impNow});
            check({27'h0, ioImpedance}, {27'h0, impNow});
        end
        for (int k = 0; k < 64; k++) pat[k] = 8'($random(seed));
        for (int k = 0; k < 32; k++) begin
            apb(1'b1, IDX_PAT_FIRST + 10'(k), {pat[2*k+1], pat[2*k]}, 1'b0, 16'h0000);
            apb(1'b0, IDX_PAT_FIRST + 10'(k), 16'h0000, 1'b0, {pat[2*k+1], pat[2*k]});
        end
        for (int m = 0; m < 4; m++) begin
            v = 16'($random(seed));
            apb(1'b1, IDX_MASK_LO + 10'(m), v, 1'b0, 16'h0000);
            apb(1'b0, IDX_MASK_LO + 10'(m), 16'h0000, 1'b0, v);
            apb(1'b1, IDX_MASK_LO + 10'(m), 16'h0000, 1'b0, 16'h0000);
        end
        apb(1'b1, IDX_START, 16'h0000, 1'b0, 16'h0000);
        frame(0, -1, 64, 1'b1);
        frame(0, 63, 64, 1'b0);
        frame(0, 0, 64, 1'b0);
        frame(0, -1, 32, 1'b0);
        apb(1'b1, IDX_MASK_THIRD, 16'h0100, 1'b0, 16'h0000);
        frame(0, 40, 64, 1'b1);
        frame(0, 41, 64, 1'b0);
        apb(1'b1, IDX_MASK_THIRD, 16'h0000, 1'b0, 16'h0000);
        apb(1'b1, IDX_MASK_LO, 16'hFFFF, 1'b0, 16'h0000);
        frame(0, 7, 64, 1'b1);
        apb(1'b1, IDX_MASK_LO, 16'h0000, 1'b0, 16'h0000);
        apb(1'b1, IDX_START, 16'h003F, 1'b0, 16'h0000);
        frame(63, -1, 64, 1'b1);
        frame(63, 63, 64, 1'b0);
        apb(1'b1, IDX_START, 16'h0005, 1'b0, 16'h0000);
        frame(5, 0, 64, 1'b0);
        frame(5, -1, 64, 1'b1);
        foreach (codes[k]) clk_run(codes[k], 1'b0, srcs[k]);
        clk_run(CLK_REF, 1'b1, 8);
        for (int c = 0; c < 4; c++) div_run(c);
        repeat (4) @(posedge mclk);
        results();
    end
endmodule // testbench
